// ### include/dmacp_pkg.sv
// Constants for the DMA channel cell-size, cell-progress and pattern block.
// Assumes a plain register port with 32-bit data and byte addresses.
package dmacp_pkg;
   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0]  OFS_CELL_SIZE     = 8'h00;
   localparam logic [7:0]  OFS_CELL_PROGRESS = 8'h04;
   localparam logic [7:0]  OFS_PATTERN_BYTE  = 8'h08;
   localparam logic [7:0]  OFS_CHANNEL_MODE  = 8'h0c;
   // ***************************************************************
   // Fields and reset values
   // ***************************************************************
   localparam int          CELL_W            = 16;
   localparam int          PAT_W             = 8;
   localparam int          BYTES_W           = 3;
   localparam logic [15:0] CELL_SIZE_RST     = 16'h0000;
   localparam logic [15:0] PROGRESS_RST      = 16'h0000;
   localparam logic [7:0]  PATTERN_RST       = 8'h00;
   localparam int          MODE_PDET_BIT     = 0;
   localparam int          MODE_PTERM_BIT    = 1;
   localparam logic [1:0]  MODE_RST          = 2'h0;
   localparam logic [16:0] CELL_ZERO_BYTES   = 17'h10000;
endpackage : dmacp_pkg

// ### rtl/dmacp_channel.sv
// Cell-size, cell-progress and pattern-match bookkeeping for one DMA channel.
// Assumes the transfer engine pulses cellStart and reports bytes moved per beat.
`timescale 1ns/1ps
module dmacp_channel
   import dmacp_pkg::*;
(
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               reset,
   // Register port
   input  wire logic [7:0]         regAddr,
   input  wire logic [31:0]        regWrData,
   input  wire logic               regWrite,
   input  wire logic               regRead,
   output logic      [31:0]        regRdData,
   // Transfer engine
   input  wire logic               cellStart,
   input  wire logic               beatValid,
   input  wire logic [BYTES_W-1:0] beatBytes,
   input  wire logic [PAT_W-1:0]   beatData,
   // Status to the engine
   output logic      [16:0]        cellBytes,
   output logic                    cellDone,
   output logic                    patternHit,
   output logic                    patternTerminate
);
   // ***************************************************************
   // State
   // ***************************************************************
   logic [CELL_W-1:0] cellSize,      next_cellSize;
   logic [CELL_W-1:0] progress,      next_progress;
   logic [PAT_W-1:0]  patternByte,   next_patternByte;
   logic [1:0]        mode,          next_mode;
   logic [31:0]       next_regRdData;
   logic [16:0]       next_cellBytes;
   logic              next_cellDone;
   logic              next_patternHit;
   logic              next_patternTerminate;
   logic [16:0]       sum;
   logic              match;

   function automatic logic [16:0] cellTotal(input logic [CELL_W-1:0] sz);
      cellTotal = (sz == 16'h0000) ? CELL_ZERO_BYTES : {1'b0, sz};
   endfunction : cellTotal

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   // The read mux pads to 32 bits by hand, so other widths would misalign
   if (CELL_W != 16 || PAT_W != 8 || BYTES_W < 1 || BYTES_W > CELL_W) begin : g_bad_widths
      $error("dmacp_channel: unsupported field widths");
   end

   // ***************************************************************
   // Configuration registers
   // ***************************************************************
   always_comb begin
      next_cellSize    = cellSize;
      next_patternByte = patternByte;
      next_mode        = mode;
      if (regWrite) begin
         case (regAddr)
            OFS_CELL_SIZE:    next_cellSize    = regWrData[CELL_W-1:0];
            OFS_PATTERN_BYTE: next_patternByte = regWrData[PAT_W-1:0];
            OFS_CHANNEL_MODE: next_mode        = regWrData[1:0];
            // Progress and unmapped offsets swallow the write
            default:          next_cellSize    = cellSize;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cellSize    <= CELL_SIZE_RST;
         patternByte <= PATTERN_RST;
         mode        <= MODE_RST;
      end else begin
         cellSize    <= next_cellSize;
         patternByte <= next_patternByte;
         mode        <= next_mode;
      end
   end

   // ***************************************************************
   // Beat decode
   // ***************************************************************
   always_comb begin
      sum   = 17'({1'b0, progress}) + 17'(beatBytes);
      match = beatValid && (beatData == patternByte);
   end

   // ***************************************************************
   // Cell progress counter
   // ***************************************************************
   always_comb begin
      next_progress = progress;
      // Progress ignores writes; the engine alone moves it
      // A new event wins over a match, so the bytes of that beat are not counted
      if (cellStart) begin
         next_progress = PROGRESS_RST;
      end else if (match && mode[MODE_PDET_BIT]) begin
         next_progress = PROGRESS_RST;
      end else if (beatValid) begin
         next_progress = sum[CELL_W-1:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         progress <= PROGRESS_RST;
      end else begin
         progress <= next_progress;
      end
   end

   // ***************************************************************
   // Status to the engine
   // ***************************************************************
   always_comb begin
      // A beat that reaches the full cell flags done; 65536 wraps to zero
      next_cellDone         = beatValid && !cellStart
                              && (sum == cellTotal(cellSize));
      next_patternHit       = match && mode[MODE_PDET_BIT] && !cellStart;
      next_patternTerminate = match && mode[MODE_PTERM_BIT];
      // Decoded ahead so the engine never sees a raw zero size
      next_cellBytes        = cellTotal(next_cellSize);
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cellBytes        <= CELL_ZERO_BYTES;
         cellDone         <= 1'b0;
         patternHit       <= 1'b0;
         patternTerminate <= 1'b0;
      end else begin
         cellBytes        <= next_cellBytes;
         cellDone         <= next_cellDone;
         patternHit       <= next_patternHit;
         patternTerminate <= next_patternTerminate;
      end
   end

   // ***************************************************************
   // Register read port
   // ***************************************************************
   always_comb begin
      // Idle cycles return zero so a stale word never looks like a fresh read
      next_regRdData = 32'h0000_0000;
      if (regRead) begin
         case (regAddr)
            OFS_CELL_SIZE:     next_regRdData = {16'h0000, cellSize};
            OFS_CELL_PROGRESS: next_regRdData = {16'h0000, progress};
            OFS_PATTERN_BYTE:  next_regRdData = {24'h000000, patternByte};
            OFS_CHANNEL_MODE:  next_regRdData = {30'h0, mode};
            default:           next_regRdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdData <= 32'h0000_0000;
      end else begin
         regRdData <= next_regRdData;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   AST_ZERO_SIZE: assert property (@(posedge mclk) disable iff (reset)
      (cellSize == 16'h0000) |=> (cellBytes == 17'h10000 || $past(regWrite)))
      else $error("zero cell size not 65536");
   AST_PROG_ADD: assert property (@(posedge mclk) disable iff (reset)
      (beatValid && !cellStart && !(match && mode[MODE_PDET_BIT]))
      |=> (progress == 16'($past(progress) + 16'($past(beatBytes)))))
      else $error("progress did not add beat bytes");
   AST_PROG_START: assert property (@(posedge mclk) disable iff (reset)
      cellStart |=> (progress == 16'h0000))
      else $error("progress not cleared on event");
   AST_PDET_CLR: assert property (@(posedge mclk) disable iff (reset)
      (match && mode[MODE_PDET_BIT]) |=> (progress == 16'h0000))
      else $error("pattern detect did not clear progress");
   AST_PTERM_OFF: assert property (@(posedge mclk) disable iff (reset)
      !$past(mode[MODE_PTERM_BIT]) |-> !patternTerminate)
      else $error("pattern used outside terminate mode");
   AST_CELL_HI: assert property (@(posedge mclk) disable iff (reset)
      $past(regRead) && ($past(regAddr) == OFS_CELL_SIZE
         || $past(regAddr) == OFS_CELL_PROGRESS) |-> (regRdData[31:16] == 16'h0000))
      else $error("cell register high bits not zero");
   AST_PAT_HI: assert property (@(posedge mclk) disable iff (reset)
      $past(regRead) && ($past(regAddr) == OFS_PATTERN_BYTE)
      |-> (regRdData == {24'h000000, $past(patternByte)}))
      else $error("pattern readback wrong");
   AST_PROG_HOLD: assert property (@(posedge mclk) disable iff (reset)
      (!beatValid && !cellStart) |=> $stable(progress))
      else $error("progress moved without a beat");
   AST_CELL_RANGE: assert property (@(posedge mclk) disable iff (reset)
      (cellBytes != 17'h00000) && (cellBytes <= CELL_ZERO_BYTES))
      else $error("cell byte count out of range");
   AST_DONE_BEAT: assert property (@(posedge mclk) disable iff (reset)
      cellDone |-> ($past(beatValid) && !$past(cellStart)))
      else $error("cell done without a beat");
   AST_HIT_MODE: assert property (@(posedge mclk) disable iff (reset)
      patternHit |-> ($past(mode[MODE_PDET_BIT]) && $past(match)))
      else $error("pattern hit outside detect mode");
   AST_TERM_MATCH: assert property (@(posedge mclk) disable iff (reset)
      patternTerminate |-> ($past(beatValid) && ($past(beatData) == $past(patternByte))))
      else $error("terminate without a pattern match");
   AST_RD_IDLE: assert property (@(posedge mclk) disable iff (reset)
      !$past(regRead) |-> (regRdData == 32'h0000_0000))
      else $error("read data not zero when idle");
   AST_PAT_STORE: assert property (@(posedge mclk) disable iff (reset)
      ($past(regWrite) && ($past(regAddr) == OFS_PATTERN_BYTE))
      |-> (patternByte == $past(regWrData[PAT_W-1:0])))
      else $error("pattern byte not stored");
endmodule : dmacp_channel

// ### verif/dmacp_channel_tb.sv
// Self-checking bench for the DMA channel cell and pattern block.
// Assumes dmacp_pkg and dmacp_channel are compiled before it.
`timescale 1ns/1ps
module dmacp_channel_tb
   import dmacp_pkg::*;
;
   logic mclk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, cellStart = 1'b0;
   logic beatValid = 1'b0, cellDone, patternHit, patternTerminate;
   logic [7:0]  regAddr = 8'h00, beatData = 8'h00;
   logic [31:0] regWrData = 32'h0, regRdData;
   logic [BYTES_W-1:0] beatBytes = 3'h0;
   logic [16:0] cellBytes;
   int          n_fail = 0, total_checks = 0, cyc = 0;
   dmacp_channel dut_u (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .cellStart(cellStart),
      .beatValid(beatValid), .beatBytes(beatBytes), .beatData(beatData), .cellBytes(cellBytes),
      .cellDone(cellDone), .patternHit(patternHit), .patternTerminate(patternTerminate));
   initial forever #5 mclk = ~mclk;
   // ********************************
   // Bus and engine helpers
   // ********************************
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWrite <= 1'b1; regAddr <= a; regWrData <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      regRead <= 1'b1; regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 chk(nm, exp, regRdData);
   endtask : rd
   // Expected pulses given as done, hit, terminate
   task beat(input logic [2:0] b, input logic [7:0] d, input logic [2:0] exp);
      @(posedge mclk);
      beatValid <= 1'b1; beatBytes <= b; beatData <= d;
      @(posedge mclk);
      beatValid <= 1'b0;
      #1 chk("pulses", exp, {cellDone, patternHit, patternTerminate});
   endtask : beat
   task start;
      @(posedge mclk);
      cellStart <= 1'b1;
      @(posedge mclk);
      cellStart <= 1'b0;
   endtask : start
   // ********************************
   // Scenarios
   // ********************************
   task t_reset;
      #1 chk("cellBytes", 32'h10000, cellBytes);
      rd("size", OFS_CELL_SIZE, 32'h0);
      rd("progress", OFS_CELL_PROGRESS, 32'h0);
      rd("pattern", OFS_PATTERN_BYTE, 32'h0);
   endtask : t_reset
   task t_count;
      wr(OFS_CELL_SIZE, 32'hffff_0005);
      rd("size", OFS_CELL_SIZE, 32'h5);
      chk("cellBytes", 32'h5, cellBytes);
      start();
      beat(3'h2, 8'h00, 3'b000);
      beat(3'h3, 8'h00, 3'b100);
      wr(OFS_CELL_PROGRESS, 32'h1234);
      rd("progress", OFS_CELL_PROGRESS, 32'h5);
      start();
      rd("progress", OFS_CELL_PROGRESS, 32'h0);
      rd("unmapped", 8'h10, 32'h0);
   endtask : t_count
   task t_pattern;
      wr(OFS_CHANNEL_MODE, 32'h1);
      wr(OFS_PATTERN_BYTE, 32'hffff_ffa5);
      rd("pattern", OFS_PATTERN_BYTE, 32'ha5);
      // Keep the match beat short of the cell size so done stays low
      beat(3'h3, 8'h11, 3'b000);
      beat(3'h1, 8'ha5, 3'b010);
      rd("progress", OFS_CELL_PROGRESS, 32'h0);
      wr(OFS_CHANNEL_MODE, 32'hffff_fffe);
      rd("mode", OFS_CHANNEL_MODE, 32'h2);
      beat(3'h1, 8'ha5, 3'b001);
      wr(OFS_CHANNEL_MODE, 32'h0);
      beat(3'h1, 8'ha5, 3'b000);
      wr(OFS_CELL_SIZE, 32'h0);
      #1 chk("cellBytes", 32'h10000, cellBytes);
   endtask : t_pattern
   task conclude;
      $display("checks %0d errors %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   // A hang is cut short well past the sixty or so cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_count();
      t_pattern();
      conclude();
   end
endmodule : dmacp_channel_tb
